//--- hw/drt_defs.svh
`ifndef DRT_DEFS_SVH
`define DRT_DEFS_SVH

// register byte offsets on the control bus
`define DRT_CTRL_LO_OFS 12'h058
`define DRT_CTRL_HI_OFS 12'h05C
`define DRT_STATUS_OFS 12'h060

// reset value and writable bits of the 64-bit control register
`define DRT_CTRL_RESET 64'h0000_0000_0000_0000
`define DRT_CTRL_WMASK 64'h0001_FFFF_FFFF_FFFF

// field positions inside the control register
`define DRT_GSW_MSB 48
`define DRT_GSW_LSB 41
`define DRT_GTHR_MSB 40
`define DRT_GTHR_LSB 28
`define DRT_DUR_MSB 27
`define DRT_DUR_LSB 22
`define DRT_MONW_MSB 21
`define DRT_MONW_LSB 15
`define DRT_WMAX_MSB 14
`define DRT_WMAX_LSB 3
`define DRT_MODE_MSB 2
`define DRT_MODE_LSB 1
`define DRT_SWSTART_BIT 0

// mode field codes
`define DRT_MODE_OFF 2'h0
`define DRT_MODE_HW 2'h1
`define DRT_MODE_CTR 2'h2

// timing: host clocks in one unit of the global sampling window
`define DRT_GLOBAL_UNIT_CLKS 400000
// threshold scale is two to this power; monitor window padding bits
`define DRT_THR_SHIFT 15
`define DRT_MON_PAD 4

// bus responses
`define DRT_RESP_OKAY 2'h0
`define DRT_RESP_DECERR 2'h3

`endif

//--- hw/drt_pkg.sv
package drt_pkg;

    // requests from the bus master toward this slave
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } drt_axil_req_t;

    // answers from this slave
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } drt_axil_rsp_t;

    // register selected by a bus address
    typedef enum logic [1:0] {
        DRT_SEL_CTRL_LO,
        DRT_SEL_CTRL_HI,
        DRT_SEL_STATUS,
        DRT_SEL_NONE
    } drt_sel_t;

    // counter mechanism phase
    typedef enum logic {
        DRT_PH_SAMPLE,
        DRT_PH_THROTTLE
    } drt_phase_t;

    // complete state of the block
    typedef struct packed {
        drt_axil_rsp_t rsp;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [63:0] ctrl;
        logic [2:0] sync;
        logic hw_req;
        logic hw_prev;
        logic sw_prev;
        drt_phase_t phase;
        logic [18:0] presc;
        logic [7:0] units;
        logic [28:0] gcnt;
        logic [5:0] dur;
        logic [10:0] mcnt;
        logic [11:0] wcnt;
        logic throttle_active;
        logic rd_block;
    } drt_state_t;

endpackage : drt_pkg

//--- hw/drt_read_throttle.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "drt_defs.svh"

module drt_read_throttle #(
    parameter int GLOBAL_UNIT_CLKS = `DRT_GLOBAL_UNIT_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire drt_pkg::drt_axil_req_t s_axil_req,
    output drt_pkg::drt_axil_rsp_t s_axil_rsp,
    input wire logic thermal_on_req_pin,
    input wire logic rd_unit_done,
    output logic rd_block,
    output logic throttle_active
);

    // last prescaler count of one global window unit
    localparam logic [18:0] UNIT_LAST = 19'(GLOBAL_UNIT_CLKS - 1);

    // the whole block state lives in q; next_q is its combinational copy
    drt_pkg::drt_state_t q;
    drt_pkg::drt_state_t next_q;

    // address decode shared by the write and the read path
    function automatic drt_pkg::drt_sel_t drt_decode(input logic [11:0] addr);
        drt_pkg::drt_sel_t sel;
        sel = drt_pkg::DRT_SEL_NONE;
        if (addr[11:2] == 10'(`DRT_CTRL_LO_OFS >> 2))
        begin
            sel = drt_pkg::DRT_SEL_CTRL_LO;
        end
        else if (addr[11:2] == 10'(`DRT_CTRL_HI_OFS >> 2))
        begin
            sel = drt_pkg::DRT_SEL_CTRL_HI;
        end
        else if (addr[11:2] == 10'(`DRT_STATUS_OFS >> 2))
        begin
            sel = drt_pkg::DRT_SEL_STATUS;
        end
        return sel;
    endfunction : drt_decode

    // merge write data into an old word under the byte strobes
    function automatic logic [31:0] drt_strobe(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction : drt_strobe

    // control fields, decoded from the registered control word
    logic [7:0] gsw;
    logic [12:0] gthr;
    logic [5:0] dur_lim;
    logic [6:0] monw;
    logic [11:0] wmax;
    logic [1:0] mode;
    logic sw_start;
    logic [28:0] thr_count;
    logic [10:0] mon_len;

    assign gsw = q.ctrl[`DRT_GSW_MSB:`DRT_GSW_LSB];
    assign gthr = q.ctrl[`DRT_GTHR_MSB:`DRT_GTHR_LSB];
    assign dur_lim = q.ctrl[`DRT_DUR_MSB:`DRT_DUR_LSB];
    assign monw = q.ctrl[`DRT_MONW_MSB:`DRT_MONW_LSB];
    assign wmax = q.ctrl[`DRT_WMAX_MSB:`DRT_WMAX_LSB];
    assign mode = q.ctrl[`DRT_MODE_MSB:`DRT_MODE_LSB];
    assign sw_start = q.ctrl[`DRT_SWSTART_BIT];
    // the threshold needs 28 bits: thirteen field bits moved up by fifteen, zero-extended to 29
    assign thr_count = {1'b0, gthr, 15'h0000};
    // a zero window field gives a window that restarts every cycle
    assign mon_len = {monw, 4'h0};

    // status word: bit0 active, bit1 block, bit2 counter phase, bit3 request, 13:8 duration
    logic [31:0] status_word;
    assign status_word = {18'h00000, q.dur, 4'h0, q.hw_req,
                          (q.phase == drt_pkg::DRT_PH_THROTTLE), q.rd_block,
                          q.throttle_active};

    // per-cycle decisions of the combinational pass
    logic hw_mode;
    logic ctr_mode;
    logic hw_eff;
    logic restart;
    logic act;
    logic unit_end;
    logic window_end;
    logic [28:0] gcnt_inc;
    drt_pkg::drt_sel_t wsel;
    drt_pkg::drt_sel_t rsel;

    always_comb
    begin
        next_q = q;
        wsel = drt_pkg::DRT_SEL_NONE;
        rsel = drt_pkg::DRT_SEL_NONE;

        // pin synchroniser; the level only moves when stages two and three agree
        // stage one is read only by stage two, to keep metastability contained
        next_q.sync = {q.sync[1:0], thermal_on_req_pin};
        if (q.sync[1] == q.sync[2])
        begin
            next_q.hw_req = q.sync[2];
        end

        // write address and data are taken independently, in either order
        if (q.rsp.awready && s_axil_req.awvalid)
        begin
            next_q.aw_have = 1'b1;
            next_q.aw_addr = s_axil_req.awaddr;
        end
        if (q.rsp.wready && s_axil_req.wvalid)
        begin
            next_q.w_have = 1'b1;
            next_q.w_data = s_axil_req.wdata;
            next_q.w_strb = s_axil_req.wstrb;
        end
        if (q.rsp.bvalid && s_axil_req.bready)
        begin
            next_q.rsp.bvalid = 1'b0;
        end
        // the write lands once both halves are in and the old answer is gone
        if (next_q.aw_have && next_q.w_have && !next_q.rsp.bvalid)
        begin
            wsel = drt_decode(next_q.aw_addr);
            next_q.aw_have = 1'b0;
            next_q.w_have = 1'b0;
            next_q.rsp.bvalid = 1'b1;
            next_q.rsp.bresp = `DRT_RESP_OKAY;
            if (wsel == drt_pkg::DRT_SEL_CTRL_LO)
            begin
                next_q.ctrl[31:0] = drt_strobe(q.ctrl[31:0], next_q.w_data, next_q.w_strb)
                    & 32'(`DRT_CTRL_WMASK);
            end
            else if (wsel == drt_pkg::DRT_SEL_CTRL_HI)
            begin
                next_q.ctrl[63:32] = drt_strobe(q.ctrl[63:32], next_q.w_data, next_q.w_strb)
                    & 32'(`DRT_CTRL_WMASK >> 32);
            end
            else if (wsel == drt_pkg::DRT_SEL_NONE)
            begin
                next_q.rsp.bresp = `DRT_RESP_DECERR;
            end
        end
        // status writes are accepted and have no effect
        // a new address or data beat waits until the previous answer is taken,
        // so one write at most is ever in flight
        next_q.rsp.awready = !next_q.aw_have && !next_q.rsp.bvalid;
        next_q.rsp.wready = !next_q.w_have && !next_q.rsp.bvalid;

        // read channel: one read outstanding, answered the cycle after it is taken
        // the data is latched with rvalid, so later control writes cannot change it
        if (q.rsp.rvalid && s_axil_req.rready)
        begin
            next_q.rsp.rvalid = 1'b0;
        end
        if (q.rsp.arready && s_axil_req.arvalid)
        begin
            rsel = drt_decode(s_axil_req.araddr);
            next_q.rsp.rvalid = 1'b1;
            next_q.rsp.rresp = `DRT_RESP_OKAY;
            next_q.rsp.rdata = 32'h0000_0000;
            if (rsel == drt_pkg::DRT_SEL_CTRL_LO)
            begin
                next_q.rsp.rdata = q.ctrl[31:0];
            end
            else if (rsel == drt_pkg::DRT_SEL_CTRL_HI)
            begin
                next_q.rsp.rdata = q.ctrl[63:32];
            end
            else if (rsel == drt_pkg::DRT_SEL_STATUS)
            begin
                next_q.rsp.rdata = status_word;
            end
            else
            begin
                next_q.rsp.rresp = `DRT_RESP_DECERR;
            end
        end
        next_q.rsp.arready = !next_q.rsp.rvalid;

        // mode 11 selects neither mechanism
        hw_mode = (mode == `DRT_MODE_HW);
        ctr_mode = (mode == `DRT_MODE_CTR);
        // request pin counts only in hardware mode
        hw_eff = hw_mode && q.hw_req;
        next_q.hw_prev = hw_eff;
        next_q.sw_prev = sw_start;

        // global window: units of GLOBAL_UNIT_CLKS clocks, gsw units long
        // the prescaler keeps the compare narrow; a direct clock count of the
        // longest window would need a far wider counter and comparator
        unit_end = (q.presc == UNIT_LAST);
        window_end = unit_end && (gsw != 8'h00)
            && (({1'b0, q.units} + 9'h001) >= {1'b0, gsw});
        gcnt_inc = (rd_unit_done && q.gcnt != 29'h1FFF_FFFF) ? q.gcnt + 29'h0000001 : q.gcnt;

        // counter mechanism; outside counter mode it sits idle at zero
        // sampling counts units against the threshold, throttling counts windows
        if (!ctr_mode)
        begin
            next_q.phase = drt_pkg::DRT_PH_SAMPLE;
            next_q.presc = 19'h00000;
            next_q.units = 8'h00;
            next_q.gcnt = 29'h0000000;
            next_q.dur = 6'h00;
        end
        else
        begin
            next_q.presc = unit_end ? 19'h00000 : q.presc + 19'h00001;
            next_q.units = unit_end ? q.units + 8'h01 : q.units;
            case (q.phase)
                drt_pkg::DRT_PH_SAMPLE:
                begin
                    next_q.gcnt = gcnt_inc;
                    // invoke on the unit that crosses the threshold, not at window end
                    if (gcnt_inc > thr_count)
                    begin
                        // a fresh window train measures the throttle duration
                        next_q.phase = drt_pkg::DRT_PH_THROTTLE;
                        next_q.presc = 19'h00000;
                        next_q.units = 8'h00;
                        next_q.gcnt = 29'h0000000;
                        next_q.dur = 6'h00;
                    end
                    else if (window_end)
                    begin
                        // the count is per window, so each window starts over
                        next_q.gcnt = 29'h0000000;
                        next_q.units = 8'h00;
                    end
                end
                drt_pkg::DRT_PH_THROTTLE:
                begin
                    // a zero duration ends throttling on the cycle after it began
                    if (q.dur >= dur_lim)
                    begin
                        next_q.phase = drt_pkg::DRT_PH_SAMPLE;
                        next_q.presc = 19'h00000;
                        next_q.units = 8'h00;
                        next_q.gcnt = 29'h0000000;
                        next_q.dur = 6'h00;
                    end
                    else if (window_end)
                    begin
                        next_q.dur = q.dur + 6'h01;
                        next_q.units = 8'h00;
                    end
                end
                // unreachable with a one-bit phase, kept as a safe fallback
                default:
                begin
                    next_q.phase = drt_pkg::DRT_PH_SAMPLE;
                end
            endcase
        end

        // any source may demand throttling; a falling pin or software source restarts the windows
        // the previous-level flops reset low like idle sources, so no false
        // restart follows reset
        restart = (q.hw_prev && !hw_eff) || (q.sw_prev && !sw_start);
        act = sw_start || hw_eff
            || (ctr_mode && q.phase == drt_pkg::DRT_PH_THROTTLE);
        next_q.throttle_active = act;

        // monitoring window and its read counter
        // limitation: a read in the last cycle of a window is not counted,
        // because that cycle clears the count for the next window
        if (!act || restart)
        begin
            next_q.mcnt = 11'h000;
            next_q.wcnt = 12'h000;
        end
        else if ((q.mcnt + 11'h001) >= mon_len)
        begin
            next_q.mcnt = 11'h000;
            next_q.wcnt = 12'h000;
        end
        else
        begin
            next_q.mcnt = q.mcnt + 11'h001;
            if (rd_unit_done && q.wcnt != 12'hFFF)
            begin
                next_q.wcnt = q.wcnt + 12'h001;
            end
        end
        // block holds for the rest of the window once the maximum is met
        // the next count is used so the block rises at the edge that reaches it
        next_q.rd_block = act && !restart && (next_q.wcnt >= wmax);
    end

    // single state register; synchronous reset to the documented defaults
    // synchroniser stages clear too, so the request reads low until three
    // fresh samples of the pin have been taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.ctrl <= `DRT_CTRL_RESET;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
            q.phase <= drt_pkg::DRT_PH_SAMPLE;
        end
        else
        begin
            q <= next_q;
        end
    end

    // every output comes straight from the state register
    assign s_axil_rsp = q.rsp;
    assign rd_block = q.rd_block;
    assign throttle_active = q.throttle_active;

endmodule : drt_read_throttle

//--- tb/drt_read_throttle_assertions.sv
`timescale 1ns/1ps
module drt_read_throttle_assertions #(
    parameter int GLOBAL_UNIT_CLKS = 400000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire drt_pkg::drt_axil_req_t s_axil_req,
    input wire drt_pkg::drt_axil_rsp_t s_axil_rsp,
    input wire logic thermal_on_req_pin,
    input wire logic rd_unit_done,
    input wire logic rd_block,
    input wire logic throttle_active
);
    logic ar_bad;
    logic aw_bad;

    // addresses outside the three mapped words
    assign ar_bad = !(s_axil_req.araddr inside {12'h058, 12'h05C, 12'h060});
    assign aw_bad = !(s_axil_req.awaddr inside {12'h058, 12'h05C, 12'h060});

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // handshakes that start a read or a write
    sequence s_ar_take;
        s_axil_req.arvalid && s_axil_rsp.arready;
    endsequence
    sequence s_aw_w_take;
        s_axil_req.awvalid && s_axil_rsp.awready && s_axil_req.wvalid && s_axil_rsp.wready;
    endsequence

    a_block_needs_active: assert property (rd_block |-> throttle_active)
        else $error("read block seen without throttling");
    a_write_answer: assert property (s_aw_w_take |=> s_axil_rsp.bvalid && !s_axil_rsp.awready)
        else $error("write response missing after address and data");
    a_read_answer: assert property (s_ar_take |=> s_axil_rsp.rvalid && !s_axil_rsp.arready)
        else $error("read response missing after address");
    a_b_stands: assert property (s_axil_rsp.bvalid && !s_axil_req.bready
        |=> s_axil_rsp.bvalid && $stable(s_axil_rsp.bresp))
        else $error("write response dropped before taken");
    a_r_stands: assert property (s_axil_rsp.rvalid && !s_axil_req.rready
        |=> s_axil_rsp.rvalid && $stable(s_axil_rsp.rdata))
        else $error("read data dropped before taken");
    a_r_once: assert property (s_axil_rsp.rvalid && s_axil_req.rready |=> !s_axil_rsp.rvalid)
        else $error("read response repeated");
    a_read_decerr: assert property (s_ar_take and ar_bad
        |=> s_axil_rsp.rresp == 2'h3 && s_axil_rsp.rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_write_decerr: assert property (s_aw_w_take and aw_bad |=> s_axil_rsp.bresp == 2'h3)
        else $error("unmapped write not refused");
    a_hi_reserved: assert property (s_ar_take and s_axil_req.araddr == 12'h05C
        |=> s_axil_rsp.rdata[31:17] == 15'h0000)
        else $error("reserved control bits read nonzero");
endmodule : drt_read_throttle_assertions

bind drt_read_throttle drt_read_throttle_assertions #(
    .GLOBAL_UNIT_CLKS(GLOBAL_UNIT_CLKS)
) drt_read_throttle_assertions_i (
    .aclk(aclk), .aresetn(aresetn), .s_axil_req(s_axil_req), .s_axil_rsp(s_axil_rsp),
    .thermal_on_req_pin(thermal_on_req_pin), .rd_unit_done(rd_unit_done),
    .rd_block(rd_block), .throttle_active(throttle_active)
);

//--- tb/drt_rd_path_model.sv
`timescale 1ns/1ps
module drt_rd_path_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic slow,
    input wire logic [31:0] budget,
    input wire logic rd_block,
    output logic rd_unit_done,
    output int issued
);
    logic ph;

    // read path: one unit per grant, every other cycle when slow; a block
    // only stops requests not yet issued, as in the real path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph <= 1'b0;
            rd_unit_done <= 1'b0;
            issued <= 0;
        end
        else
        begin
            ph <= !ph;
            rd_unit_done <= 1'b0;
            if (go && !rd_block && issued < budget && (!slow || ph))
            begin
                rd_unit_done <= 1'b1;
                issued <= issued + 1;
            end
        end
    end
endmodule : drt_rd_path_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic thermal_on_req_pin = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b1;
    int budget = 1000000;
    int issued;
    int cyc = 0;
    int bad_count = 0;
    int samples_checked = 0;
    int nr, nu, n;
    logic pb;
    logic rd_unit_done, rd_block, throttle_active;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [6:0] win[2] = '{7'h02, 7'h01};
    logic [11:0] mx[2] = '{12'h003, 12'h001};
    drt_pkg::drt_axil_req_t req = '0;
    drt_pkg::drt_axil_rsp_t rsp;

    always #10 aclk = !aclk;

    drt_read_throttle #(.GLOBAL_UNIT_CLKS(200)) drt_read_throttle_i (
        .aclk(aclk), .aresetn(aresetn), .s_axil_req(req), .s_axil_rsp(rsp),
        .thermal_on_req_pin(thermal_on_req_pin), .rd_unit_done(rd_unit_done),
        .rd_block(rd_block), .throttle_active(throttle_active)
    );
    drt_rd_path_model drt_rd_path_model_i (
        .aclk(aclk), .aresetn(aresetn), .go(go), .slow(slow), .budget(budget),
        .rd_block(rd_block), .rd_unit_done(rd_unit_done), .issued(issued)
    );

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic clk(input int k);
        repeat (k) @(posedge aclk);
    endtask : clk

    // handshake state is judged mid-cycle, so the edge decision never races
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic [2:0] tk;
        @(posedge aclk);
        tk = 3'h0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        while (!tk[0])
        begin
            @(negedge aclk);
            tk = {req.awvalid && rsp.awready, req.wvalid && rsp.wready, rsp.bvalid};
            rs = rsp.bresp;
            @(posedge aclk);
            if (tk[2]) req.awvalid <= 1'b0;
            if (tk[1]) req.wvalid <= 1'b0;
            if (tk[0]) req.bready <= 1'b0;
        end
    endtask : axw

    task automatic axr(input logic [11:0] a);
        logic [1:0] tk;
        @(posedge aclk);
        tk = 2'h0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!tk[0])
        begin
            @(negedge aclk);
            tk = {req.arvalid && rsp.arready, rsp.rvalid};
            rd = rsp.rdata;
            rs = rsp.rresp;
            @(posedge aclk);
            if (tk[1]) req.arvalid <= 1'b0;
            if (tk[0]) req.rready <= 1'b0;
        end
    endtask : axr

    task automatic test_end(input string t);
        $display("test %s done", t);
    endtask : test_end

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // hang guard; the counter test alone takes about 73000 cycles
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    initial
    begin
        clk(16);
        aresetn <= 1'b1;
        axr(12'h058);
        chk("ctrl_lo_reset", rd, 32'h0000_0000);
        axr(12'h05C);
        chk("ctrl_hi_reset", rd, 32'h0000_0000);
        axr(12'h064);
        chk("unmapped_rresp", rs, 32'h0000_0003);
        chk("unmapped_rdata", rd, 32'h0000_0000);
        axw(12'h05C, 32'hFFFF_FFFF);
        axr(12'h05C);
        chk("ctrl_hi_mask", rd, 32'h0001_FFFF);
        axw(12'h100, 32'h0000_0000);
        chk("unmapped_bresp", rs, 32'h0000_0003);
        axw(12'h05C, 32'h0000_0000);
        test_end("registers");
        // software start over four monitor windows per setting
        for (int i = 0; i < 2; i++)
        begin
            axw(12'h058, {10'h000, win[i], mx[i], 2'h0, 1'b1});
            // reads start once the window runs, so every counted unit is seen
            go <= 1'b1;
            nr = 0;
            nu = 0;
            pb = 1'b0;
            repeat (64 * win[i])
            begin
                @(negedge aclk);
                nu += rd_unit_done;
                nr += rd_block && !pb;
                pb = rd_block;
            end
            chk("block_per_window", nr, 32'h0000_0004);
            chk("reads_per_window", nu >= 4 * mx[i] && nu <= 4 * mx[i] + 2, 32'h1);
            axr(12'h060);
            chk("status_active", rd[0], 32'h1);
            axw(12'h058, 32'h0000_0000);
            go <= 1'b0;
            clk(1);
            chk("sw_stop_active", throttle_active, 32'h0);
            chk("sw_stop_block", rd_block, 32'h0);
        end
        go <= 1'b0;
        test_end("sw_start");
        // request pin held high under every mode code
        thermal_on_req_pin <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            axw(12'h058, {29'h0, m[1:0], 1'b0});
            clk(10);
            chk("pin_mode", throttle_active, m == 1);
        end
        axw(12'h058, 32'h0000_0002);
        clk(10);
        thermal_on_req_pin <= 1'b0;
        clk(10);
        chk("pin_release", throttle_active, 32'h0);
        test_end("pin");
        // counter mode: threshold 32768 units, window 200 units, one window long
        thermal_on_req_pin <= 1'b1;
        slow <= 1'b0;
        // the model's issue count runs on from earlier tests, so budgets are relative
        budget <= issued + 32768;
        axw(12'h05C, 32'h0001_9000);
        axw(12'h058, 32'h1040_FFFC);
        go <= 1'b1;
        while (issued < budget) @(posedge aclk);
        clk(20);
        chk("ctr_at_threshold", throttle_active, 32'h0);
        budget <= budget + 1;
        clk(20);
        chk("ctr_over_threshold", throttle_active, 32'h1);
        n = 0;
        while (throttle_active === 1'b1 && n < 41000)
        begin
            @(negedge aclk);
            n++;
        end
        chk("ctr_duration", n >= 39975 && n <= 39990, 32'h1);
        budget <= budget + 200;
        clk(300);
        chk("ctr_restart", throttle_active, 32'h0);
        go <= 1'b0;
        test_end("counter");
        wrap_up();
    end
endmodule : tb_top
